// file: core/osel_pkg.sv
// Shared constants, types and decode functions for output clock selection
`default_nettype none
package osel_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SEL_THREE_FOUR = 8'h61;
    localparam logic [7:0] ADDR_SEL_FIVE_SIX = 8'h62;
    localparam logic [7:0] ADDR_SEL_SEVEN_SYNC = 8'h63;
    localparam logic [7:0] ADDR_SEC_FREQ = 8'h64;
    // Reset values
    localparam logic [7:0] RST_SEL_THREE_FOUR = 8'h86;
    localparam logic [7:0] RST_SEL_FIVE_SIX = 8'h84;
    localparam logic [7:0] RST_SEL_SEVEN_SYNC = 8'hC6;
    localparam logic [7:0] RST_SEC_FREQ = 8'h05;
    // Implemented bits, the rest read zero
    localparam logic [7:0] MASK_SEVEN_SYNC = 8'hCF;
    localparam logic [7:0] MASK_SEC_FREQ = 8'h0F;
    // Field positions
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 4;
    localparam int SEL_W = 4;
    localparam int MFS_EN_BIT = 7;
    localparam int FS_EN_BIT = 6;
    localparam logic [3:0] SEC_FREQ_OFF = 4'h0;
    // Output indices
    localparam int OUT_THREE = 0;
    localparam int OUT_FOUR = 1;
    localparam int OUT_FIVE = 2;
    localparam int OUT_SIX = 3;
    localparam int OUT_SEVEN = 4;
    localparam int NUM_OUT = 5;
    // Frame tone timing
    localparam int MCLK_PERIOD_NS = 100;
    localparam int FRAME8K_PERIOD_NS = 125000;
    localparam int FRAME2K_PERIOD_NS = 500000;
    localparam int FRAME8K_CYCLES = FRAME8K_PERIOD_NS / MCLK_PERIOD_NS;
    localparam int FRAME2K_CYCLES_DFLT = FRAME2K_PERIOD_NS / MCLK_PERIOD_NS;
    // Common multiple of all divide ratios
    localparam logic [9:0] DIV_WRAP = 10'h3C0;

    // Register port request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wrData;
    } osel_regReq_t;

    // Divided versions of one source
    typedef struct packed {
        logic d2;
        logic d4;
        logic d5;
        logic d6;
        logic d8;
        logic d10;
        logic d12;
        logic d16;
        logic d20;
        logic d48;
        logic d64;
    } osel_taps_t;

    // Every selectable clock
    typedef struct packed {
        logic tone2k;
        logic tone8k;
        logic syn1;
        logic syn2;
        logic refS;
        logic refP;
        logic p1;
        logic s1;
        logic a1;
        osel_taps_t pDiv;
        osel_taps_t sDiv;
        osel_taps_t aDiv;
    } osel_srcs_t;

    typedef enum logic [4:0] {
        SRC_LOW, SRC_2K, SRC_8K, SRC_SYN1, SRC_SYN2, SRC_REF_S, SRC_REF_P,
        SRC_P1, SRC_P2, SRC_P4, SRC_P6, SRC_P8, SRC_P10, SRC_P12, SRC_P16, SRC_P48, SRC_P64,
        SRC_S1, SRC_S2, SRC_S4, SRC_S5, SRC_S8, SRC_S10, SRC_S12, SRC_S16, SRC_S20,
        SRC_S48, SRC_S64, SRC_A1, SRC_A2, SRC_A5, SRC_A10
    } osel_src_t;

    // Select code to source, standard or alternate table
    function automatic osel_src_t osel_decode(input int idx, input logic alt,
                                              input logic [3:0] code);
        osel_src_t s;
        s = SRC_LOW;
        if (!alt)
        begin
            case (code)
                4'h1: s = SRC_2K;
                4'h2: s = SRC_8K;
                4'h3: s = (idx == OUT_SIX) ? SRC_P2 : SRC_SYN2;
                4'h4: s = (idx == OUT_SEVEN) ? SRC_P2 : SRC_SYN1;
                4'h5: s = (idx == OUT_SIX) ? SRC_P1 : SRC_P48;
                4'h6: s = SRC_P16;
                4'h7: s = SRC_P12;
                4'h8: s = SRC_P8;
                4'h9: s = SRC_P6;
                4'hA: s = SRC_P4;
                4'hB: s = (idx == OUT_FOUR || idx == OUT_FIVE) ? SRC_S2 : SRC_S64;
                4'hC: s = SRC_S48;
                4'hD: s = SRC_S16;
                4'hE: s = SRC_S8;
                4'hF: s = SRC_S4;
                default: s = SRC_LOW;
            endcase
        end
        else
        begin
            case (code)
                4'h1: s = (idx == OUT_THREE) ? SRC_P64 : (idx >= OUT_SIX) ? SRC_S5 : SRC_P2;
                4'h2: s = (idx == OUT_THREE) ? SRC_S20 : (idx == OUT_FOUR) ? SRC_P10 :
                          (idx == OUT_FIVE) ? SRC_P1 : SRC_S2;
                4'h3: s = (idx == OUT_THREE) ? SRC_S12 : (idx == OUT_FOUR) ? SRC_LOW :
                          (idx == OUT_FIVE) ? SRC_S10 : SRC_S1;
                4'h4: s = (idx == OUT_THREE) ? SRC_S10 : (idx >= OUT_SIX) ? SRC_A5 : SRC_A10;
                4'h5: s = (idx == OUT_THREE) ? SRC_S5 : SRC_A2;
                4'h6: s = (idx == OUT_THREE) ? SRC_S2 : SRC_A1;
                4'h7: s = SRC_REF_S;
                4'h8: s = SRC_REF_P;
                default: s = SRC_LOW;
            endcase
        end
        return s;
    endfunction : osel_decode

    // Source to clock level
    function automatic logic osel_pick(input osel_src_t s, input osel_srcs_t x);
        logic b;
        b = 1'b0;
        case (s)
            SRC_2K: b = x.tone2k;
            SRC_8K: b = x.tone8k;
            SRC_SYN1: b = x.syn1;
            SRC_SYN2: b = x.syn2;
            SRC_REF_S: b = x.refS;
            SRC_REF_P: b = x.refP;
            SRC_P1: b = x.p1;
            SRC_P2: b = x.pDiv.d2;
            SRC_P4: b = x.pDiv.d4;
            SRC_P6: b = x.pDiv.d6;
            SRC_P8: b = x.pDiv.d8;
            SRC_P10: b = x.pDiv.d10;
            SRC_P12: b = x.pDiv.d12;
            SRC_P16: b = x.pDiv.d16;
            SRC_P48: b = x.pDiv.d48;
            SRC_P64: b = x.pDiv.d64;
            SRC_S1: b = x.s1;
            SRC_S2: b = x.sDiv.d2;
            SRC_S4: b = x.sDiv.d4;
            SRC_S5: b = x.sDiv.d5;
            SRC_S8: b = x.sDiv.d8;
            SRC_S10: b = x.sDiv.d10;
            SRC_S12: b = x.sDiv.d12;
            SRC_S16: b = x.sDiv.d16;
            SRC_S20: b = x.sDiv.d20;
            SRC_S48: b = x.sDiv.d48;
            SRC_S64: b = x.sDiv.d64;
            SRC_A1: b = x.a1;
            SRC_A2: b = x.aDiv.d2;
            SRC_A5: b = x.aDiv.d5;
            SRC_A10: b = x.aDiv.d10;
            default: b = 1'b0;
        endcase
        return b;
    endfunction : osel_pick
endpackage : osel_pkg
`default_nettype wire

// file: core/osel_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module osel_sync #(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Pin side and clock side
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage;
    logic [W-1:0] next_stage;
    logic [W-1:0] next_dout;

    // Shift chain
    always_comb
    begin
        next_stage = din;
        next_dout = stage;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage <= '0;
            dout <= '0;
        end
        else
        begin
            stage <= next_stage;
            dout <= next_dout;
        end
    end
endmodule : osel_sync
`default_nettype wire

// file: core/osel_divider.sv
// Edge-counting divider bank for one sampled PLL clock
`default_nettype none
module osel_divider
    import osel_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Sampled source and run control
    input wire logic srcSync,
    input wire logic run,
    // Divided outputs
    output osel_taps_t taps
);
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic prev;
    logic next_prev;
    osel_taps_t next_taps;

    // High for the first n/2 (rounded down) of every n source edges
    function automatic logic tapOf(input logic [9:0] c, input int n);
        return (int'(c) % n) < (n / 2);
    endfunction : tapOf

    // Count rising edges, all taps low while stopped
    always_comb
    begin
        next_prev = srcSync;
        next_cnt = cnt;
        if (!run)
        begin
            next_cnt = 10'h000;
        end
        else if (srcSync && !prev)
        begin
            next_cnt = (cnt == DIV_WRAP - 10'h001) ? 10'h000 : cnt + 10'h001;
        end
        next_taps.d2 = run & tapOf(next_cnt, 2);
        next_taps.d4 = run & tapOf(next_cnt, 4);
        next_taps.d5 = run & tapOf(next_cnt, 5);
        next_taps.d6 = run & tapOf(next_cnt, 6);
        next_taps.d8 = run & tapOf(next_cnt, 8);
        next_taps.d10 = run & tapOf(next_cnt, 10);
        next_taps.d12 = run & tapOf(next_cnt, 12);
        next_taps.d16 = run & tapOf(next_cnt, 16);
        next_taps.d20 = run & tapOf(next_cnt, 20);
        next_taps.d48 = run & tapOf(next_cnt, 48);
        next_taps.d64 = run & tapOf(next_cnt, 64);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 10'h000;
            prev <= 1'b0;
            taps <= '0;
        end
        else
        begin
            cnt <= next_cnt;
            prev <= next_prev;
            taps <= next_taps;
        end
    end
endmodule : osel_divider
`default_nettype wire

// file: core/osel_top.sv
// Output clock source selection, frame sync pins and their registers
`default_nettype none
module osel_top
    import osel_pkg::*;
#(
    parameter int FRAME2K_CYCLES = FRAME2K_CYCLES_DFLT
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Processor register port
    input wire osel_regReq_t regReq,
    output logic [7:0] regRdData,
    // Clock sources
    input wire logic primaryAnalogPll,
    input wire logic secondaryAnalogPll,
    input wire logic auxiliaryPrimaryPll,
    input wire logic synthClockOne,
    input wire logic synthClockTwo,
    input wire logic secondaryRefDivided,
    input wire logic primaryRefDivided,
    // Decode and source controls
    input wire logic [NUM_OUT-1:0] altDecode,
    input wire logic secondaryPllSourceSelect,
    output logic [3:0] secondaryPllFreqSelect,
    // Clock and sync outputs
    output logic clockOutputThree,
    output logic clockOutputFour,
    output logic clockOutputFive,
    output logic clockOutputSix,
    output logic clockOutputSeven,
    output logic multiframeSyncPin,
    output logic frameSyncPin
);
    logic [7:0] selThreeFour;
    logic [7:0] selFiveSix;
    logic [7:0] selSevenSync;
    logic [7:0] secFreq;
    logic [7:0] next_selThreeFour;
    logic [7:0] next_selFiveSix;
    logic [7:0] next_selSevenSync;
    logic [7:0] next_secFreq;
    logic [7:0] next_regRdData;
    logic [12:0] syncBus;
    logic [NUM_OUT-1:0] altSync;
    logic secSrcSel;
    logic secRun;
    logic [3:0] sel [NUM_OUT];
    osel_taps_t pTaps;
    osel_taps_t sTaps;
    osel_taps_t aTaps;
    osel_srcs_t srcs;
    logic [10:0] cnt8k;
    logic [15:0] cnt2k;
    logic tone8k;
    logic tone2k;
    logic [10:0] next_cnt8k;
    logic [15:0] next_cnt2k;
    logic next_tone8k;
    logic next_tone2k;
    logic [NUM_OUT-1:0] clkOut;
    logic [NUM_OUT-1:0] next_clkOut;
    logic next_mfPin;
    logic next_fsPin;

    // Pin inputs into the clock domain
    osel_sync #(.W(13)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din({secondaryPllSourceSelect, altDecode, primaryRefDivided, secondaryRefDivided,
              synthClockTwo, synthClockOne, auxiliaryPrimaryPll, secondaryAnalogPll,
              primaryAnalogPll}),
        .dout(syncBus)
    );
    assign altSync = syncBus[11:7];
    assign secSrcSel = syncBus[12];

    assign secRun = secSrcSel | (secFreq[3:0] != SEC_FREQ_OFF);

    // Divider banks
    osel_divider u_divPrimary (
        .mclk(mclk),
        .nrst(nrst),
        .srcSync(syncBus[0]),
        .run(1'b1),
        .taps(pTaps)
    );
    osel_divider u_divSecondary (
        .mclk(mclk),
        .nrst(nrst),
        .srcSync(syncBus[1]),
        .run(secRun),
        .taps(sTaps)
    );
    osel_divider u_divAuxiliary (
        .mclk(mclk),
        .nrst(nrst),
        .srcSync(syncBus[2]),
        .run(1'b1),
        .taps(aTaps)
    );

    // Gather every selectable clock
    always_comb
    begin
        srcs.tone2k = tone2k;
        srcs.tone8k = tone8k;
        srcs.syn1 = syncBus[3];
        srcs.syn2 = syncBus[4];
        srcs.refS = syncBus[5];
        srcs.refP = syncBus[6];
        srcs.p1 = syncBus[0];
        srcs.s1 = syncBus[1] & secRun;
        srcs.a1 = syncBus[2];
        srcs.pDiv = pTaps;
        srcs.sDiv = sTaps;
        srcs.aDiv = aTaps;
    end

    // Select fields per output
    assign sel[OUT_THREE] = selThreeFour[SEL_LO_LSB +: SEL_W];
    assign sel[OUT_FOUR] = selThreeFour[SEL_HI_LSB +: SEL_W];
    assign sel[OUT_FIVE] = selFiveSix[SEL_LO_LSB +: SEL_W];
    assign sel[OUT_SIX] = selFiveSix[SEL_HI_LSB +: SEL_W];
    assign sel[OUT_SEVEN] = selSevenSync[SEL_LO_LSB +: SEL_W];

    // Register writes and read data
    always_comb
    begin
        next_selThreeFour = selThreeFour;
        next_selFiveSix = selFiveSix;
        next_selSevenSync = selSevenSync;
        next_secFreq = secFreq;
        next_regRdData = regRdData;
        if (regReq.write)
        begin
            case (regReq.addr)
                ADDR_SEL_THREE_FOUR: next_selThreeFour = regReq.wrData;
                ADDR_SEL_FIVE_SIX: next_selFiveSix = regReq.wrData;
                ADDR_SEL_SEVEN_SYNC: next_selSevenSync = regReq.wrData & MASK_SEVEN_SYNC;
                ADDR_SEC_FREQ: next_secFreq = regReq.wrData & MASK_SEC_FREQ;
                default: next_secFreq = secFreq;
            endcase
        end
        if (regReq.read)
        begin
            case (regReq.addr)
                ADDR_SEL_THREE_FOUR: next_regRdData = selThreeFour;
                ADDR_SEL_FIVE_SIX: next_regRdData = selFiveSix;
                ADDR_SEL_SEVEN_SYNC: next_regRdData = selSevenSync;
                ADDR_SEC_FREQ: next_regRdData = secFreq;
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    // Frame tone counters
    always_comb
    begin
        next_cnt8k = (cnt8k == 11'(FRAME8K_CYCLES - 1)) ? 11'h000 : cnt8k + 11'h001;
        next_cnt2k = (cnt2k == 16'(FRAME2K_CYCLES - 1)) ? 16'h0000 : cnt2k + 16'h0001;
        next_tone8k = next_cnt8k < 11'(FRAME8K_CYCLES / 2);
        next_tone2k = next_cnt2k < 16'(FRAME2K_CYCLES / 2);
    end

    // Output clock and sync pin levels
    always_comb
    begin
        for (int i = 0; i < NUM_OUT; i++)
        begin
            next_clkOut[i] = osel_pick(osel_decode(i, altSync[i], sel[i]), srcs);
        end
        next_mfPin = selSevenSync[MFS_EN_BIT] & tone2k;
        next_fsPin = selSevenSync[FS_EN_BIT] & tone8k;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            selThreeFour <= RST_SEL_THREE_FOUR;
            selFiveSix <= RST_SEL_FIVE_SIX;
            selSevenSync <= RST_SEL_SEVEN_SYNC;
            secFreq <= RST_SEC_FREQ;
            regRdData <= 8'h00;
            cnt8k <= 11'h000;
            cnt2k <= 16'h0000;
            tone8k <= 1'b0;
            tone2k <= 1'b0;
            clkOut <= '0;
            multiframeSyncPin <= 1'b0;
            frameSyncPin <= 1'b0;
        end
        else
        begin
            selThreeFour <= next_selThreeFour;
            selFiveSix <= next_selFiveSix;
            selSevenSync <= next_selSevenSync;
            secFreq <= next_secFreq;
            regRdData <= next_regRdData;
            cnt8k <= next_cnt8k;
            cnt2k <= next_cnt2k;
            tone8k <= next_tone8k;
            tone2k <= next_tone2k;
            clkOut <= next_clkOut;
            multiframeSyncPin <= next_mfPin;
            frameSyncPin <= next_fsPin;
        end
    end

    // Pin outputs
    assign clockOutputThree = clkOut[OUT_THREE];
    assign clockOutputFour = clkOut[OUT_FOUR];
    assign clockOutputFive = clkOut[OUT_FIVE];
    assign clockOutputSix = clkOut[OUT_SIX];
    assign clockOutputSeven = clkOut[OUT_SEVEN];
    assign secondaryPllFreqSelect = secFreq[3:0];

    // Checks on decode, pins and registers
    property p_out4Syn2;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[1] && sel[1] == 4'h3) |=> clockOutputFour == $past(srcs.syn2);
    endproperty
    a_out4Syn2: assert property (p_out4Syn2) else $error("out4 code 3 wrong");
    property p_out3P48;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[0] && sel[0] == 4'h5) |=> clockOutputThree == $past(pTaps.d48);
    endproperty
    a_out3P48: assert property (p_out3P48) else $error("out3 code 5 wrong");
    property p_out4S2;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[1] && sel[1] == 4'hB) |=> clockOutputFour == $past(sTaps.d2);
    endproperty
    a_out4S2: assert property (p_out4S2) else $error("out4 code B wrong");
    property p_out4AltA1;
        @(posedge mclk) disable iff (!nrst)
        (altSync[1] && sel[1] == 4'h6) |=> clockOutputFour == $past(srcs.a1);
    endproperty
    a_out4AltA1: assert property (p_out4AltA1) else $error("out4 alt 6 wrong");
    property p_altUndef;
        @(posedge mclk) disable iff (!nrst)
        (altSync[4] && sel[4] > 4'h8) |=> !clockOutputSeven;
    endproperty
    a_altUndef: assert property (p_altUndef) else $error("out7 undefined not low");
    property p_out6S64;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[3] && sel[3] == 4'hB) |=> clockOutputSix == $past(sTaps.d64);
    endproperty
    a_out6S64: assert property (p_out6S64) else $error("out6 code B wrong");
    property p_out3AltS20;
        @(posedge mclk) disable iff (!nrst)
        (altSync[0] && sel[0] == 4'h2) |=> clockOutputThree == $past(sTaps.d20);
    endproperty
    a_out3AltS20: assert property (p_out3AltS20) else $error("out3 alt 2 wrong");
    property p_out6P1;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[3] && sel[3] == 4'h5) |=> clockOutputSix == $past(srcs.p1);
    endproperty
    a_out6P1: assert property (p_out6P1) else $error("out6 code 5 wrong");
    property p_out7AltS1;
        @(posedge mclk) disable iff (!nrst)
        (altSync[4] && sel[4] == 4'h3) |=> clockOutputSeven == $past(srcs.s1);
    endproperty
    a_out7AltS1: assert property (p_out7AltS1) else $error("out7 alt 3 wrong");
    property p_out5Low;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[2] && sel[2] == 4'h0) [*2] |=> !clockOutputFive;
    endproperty
    a_out5Low: assert property (p_out5Low) else $error("out5 code 0 not low");
    property p_out5AltS10;
        @(posedge mclk) disable iff (!nrst)
        (altSync[2] && sel[2] == 4'h3) |=> clockOutputFive == $past(sTaps.d10);
    endproperty
    a_out5AltS10: assert property (p_out5AltS10) else $error("out5 alt 3 wrong");
    property p_out7P2;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[4] && sel[4] == 4'h4) |=> clockOutputSeven == $past(pTaps.d2);
    endproperty
    a_out7P2: assert property (p_out7P2) else $error("out7 code 4 wrong");
    property p_mfPin;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |=> multiframeSyncPin == ($past(selSevenSync[MFS_EN_BIT]) && $past(tone2k));
    endproperty
    a_mfPin: assert property (p_mfPin) else $error("multiframe pin wrong");
    property p_fsPin;
        @(posedge mclk) disable iff (!nrst)
        !selSevenSync[FS_EN_BIT] |=> !frameSyncPin;
    endproperty
    a_fsPin: assert property (p_fsPin) else $error("frame pin not low");
    property p_rw62;
        @(posedge mclk) disable iff (!nrst)
        (regReq.write && regReq.addr == ADDR_SEL_FIVE_SIX) ##1
        (regReq.read && !regReq.write && regReq.addr == ADDR_SEL_FIVE_SIX)
        |=> regRdData == $past(regReq.wrData, 2);
    endproperty
    a_rw62: assert property (p_rw62) else $error("62h readback wrong");
    property p_rw63;
        @(posedge mclk) disable iff (!nrst)
        (regReq.write && regReq.addr == ADDR_SEL_SEVEN_SYNC) ##1
        (regReq.read && !regReq.write && regReq.addr == ADDR_SEL_SEVEN_SYNC)
        |=> regRdData == ($past(regReq.wrData, 2) & MASK_SEVEN_SYNC);
    endproperty
    a_rw63: assert property (p_rw63) else $error("63h readback wrong");
    property p_out3Low;
        @(posedge mclk) disable iff (!nrst)
        (!altSync[0] && sel[0] == 4'h0) |=> !clockOutputThree;
    endproperty
    a_out3Low: assert property (p_out3Low) else $error("out3 code 0 not low");
    property p_secOff;
        @(posedge mclk) disable iff (!nrst)
        (!secSrcSel && secFreq[3:0] == SEC_FREQ_OFF) |-> (!srcs.s1) ##1 (sTaps == '0);
    endproperty
    a_secOff: assert property (p_secOff) else $error("secondary not stopped");
    property p_rd64;
        @(posedge mclk) disable iff (!nrst)
        (regReq.read && regReq.addr == ADDR_SEC_FREQ) |=> regRdData[7:4] == 4'h0;
    endproperty
    a_rd64: assert property (p_rd64) else $error("64h unused bits set");
endmodule : osel_top
`default_nettype wire

// file: verification/osel_sink.sv
// Downstream model counting sync pin pulses
`default_nettype none
module osel_sink (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Watched pins
    input wire logic mfs,
    input wire logic fs,
    // Rising edge counts
    output int mfsCnt,
    output int fsCnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mfsD;
    logic fsD;
    // Count rising edges of each pin
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mfsD <= 1'b0;
            fsD <= 1'b0;
            mfsCnt <= 0;
            fsCnt <= 0;
        end
        else
        begin
            mfsD <= mfs;
            fsD <= fs;
            mfsCnt <= mfsCnt + int'(mfs & ~mfsD);
            fsCnt <= fsCnt + int'(fs & ~fsD);
        end
    end
endmodule : osel_sink
`default_nettype wire

// file: verification/test_output_clock_frequency_select.sv
// Randomised bench for output clock selection
`default_nettype none
module test_output_clock_frequency_select;
    import osel_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, nrst = 1'b0, syn1 = 1'b0, syn2 = 1'b0, refS = 1'b0, refP = 1'b0;
    osel_regReq_t rq = '0;
    logic [4:0] alt = '0;
    logic [7:0] rdat;
    logic [3:0] sfs;
    logic [4:0] oc;
    logic mfs, fs, sps = 1'b0;
    logic [2:0] pll = '0;
    int errorCnt = 0, nTests = 0, mc, fc, m0, f0;
    localparam int FRAME2K_TB = 40;
    localparam int WIN = 1300;
    logic [23:0] dcfg [3] = '{24'hB5B0C4, 24'h6233C3, 24'hA650C5};
    logic [3:0] cd [5];
    logic [3:0] al [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hF};
    logic [3:0] sl [3] = '{4'h0, 4'h3, 4'h4};
    // Clock
    always #50 mclk = ~mclk;
    // Slow free-running loop clocks
    always @(negedge mclk) pll <= pll + 3'h1;
    osel_top #(.FRAME2K_CYCLES(FRAME2K_TB)) dut (.mclk(mclk), .nrst(nrst), .regReq(rq),
        .regRdData(rdat), .primaryAnalogPll(pll[1]), .secondaryAnalogPll(pll[2]),
        .auxiliaryPrimaryPll(~pll[1]), .synthClockOne(syn1), .synthClockTwo(syn2),
        .secondaryRefDivided(refS), .primaryRefDivided(refP), .altDecode(alt),
        .secondaryPllSourceSelect(sps), .secondaryPllFreqSelect(sfs),
        .clockOutputThree(oc[0]), .clockOutputFour(oc[1]), .clockOutputFive(oc[2]),
        .clockOutputSix(oc[3]), .clockOutputSeven(oc[4]), .multiframeSyncPin(mfs),
        .frameSyncPin(fs));
    osel_sink partner (.mclk(mclk), .nrst(nrst), .mfs(mfs), .fs(fs), .mfsCnt(mc),
        .fsCnt(fc));
    // Expected level for the static sources used here
    function automatic logic expLvl(input logic a, input logic [3:0] c);
        if (a)
            return (c == 4'h7) ? refS : (c == 4'h8) ? refP : 1'b0;
        return (c == 4'h3) ? syn2 : (c == 4'h4) ? syn1 : 1'b0;
    endfunction : expLvl
    // Register value compare
    task automatic chkReg(input string n, input logic [7:0] e, input logic [7:0] g);
        nTests++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            errorCnt++;
        end
    endtask : chkReg
    // Pin level or flag compare
    task automatic chkBit(input string n, input logic e, input logic g);
        nTests++;
        if (g !== e)
        begin
            $display("mismatch %s expected %b seen %b", n, e, g);
            errorCnt++;
        end
    endtask : chkBit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        rq = '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        rq.write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        rq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk);
        rq.read = 1'b0;
        chkReg("regRdData", e, rdat);
    endtask : rd
    // Write then read back in the next cycle
    task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(negedge mclk);
        rq = '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        rq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk);
        rq.read = 1'b0;
        chkReg("regRdData", e, rdat);
    endtask : wrRd
    task automatic endOfTest();
        if (errorCnt == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : endOfTest
    // Main sequence
    initial
    begin
        void'($urandom(32'hE2A4CB9D));
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        rd(8'h62, 8'h84);
        rd(8'h63, 8'hC6);
        rd(8'h64, 8'h05);
        chkReg("secFreq", 8'h05, {4'h0, sfs});
        // Unused bits, unmapped place
        wr(8'h64, 8'hF0);
        rd(8'h64, 8'h00);
        chkReg("secFreq", 8'h00, {4'h0, sfs});
        rd(8'h70, 8'h00);
        // Random decode picks, static sources
        for (int t = 0; t < 60; t++)
        begin
            alt = 5'($urandom);
            {syn1, syn2, refS, refP} = 4'($urandom);
            for (int i = 0; i < 5; i++)
            begin
                cd[i] = alt[i] ? al[$urandom % 5] : sl[$urandom % 3];
                if (!alt[i] && ((i == 3 && cd[i] == 4'h3) || (i == 4 && cd[i] == 4'h4)))
                    cd[i] = 4'h0;
            end
            if (alt[1] && t % 4 == 0)
                cd[1] = 4'h3;
            wr(8'h61, {cd[1], cd[0]});
            wrRd(8'h62, {cd[3], cd[2]}, {cd[3], cd[2]});
            wrRd(8'h63, {4'hF, cd[4]}, {4'hC, cd[4]});
            repeat (6) @(negedge mclk);
            for (int i = 0; i < 5; i++)
                chkBit("clockOutput", expLvl(alt[i], cd[i]), oc[i]);
        end
        // Divided sources, secondary loop kept running by its source select
        sps = 1'b1;
        for (int t = 0; t < 3; t++)
        begin
            alt = (t == 1) ? 5'h1F : 5'h00;
            wr(8'h61, dcfg[t][23:16]);
            wrRd(8'h62, dcfg[t][15:8], dcfg[t][15:8]);
            wrRd(8'h63, dcfg[t][7:0], dcfg[t][7:0]);
            repeat (300) @(negedge mclk);
        end
        // Sync pins follow enables, tone periods
        m0 = mc;
        f0 = fc;
        repeat (WIN) @(negedge mclk);
        m0 = (mc - m0) - WIN / FRAME2K_TB;
        f0 = (fc - f0) - WIN / FRAME8K_CYCLES;
        chkBit("mfsEdges", 1'b1, m0 inside {0, 1});
        chkBit("fsEdges", 1'b1, f0 inside {0, 1});
        wr(8'h63, 8'h00);
        repeat (3) @(negedge mclk);
        m0 = mc;
        f0 = fc;
        repeat (WIN) @(negedge mclk);
        chkBit("mfsIdle", 1'b1, mc == m0 && mfs === 1'b0);
        chkBit("fsIdle", 1'b1, fc == f0 && fs === 1'b0);
        endOfTest();
    end
endmodule : test_output_clock_frequency_select
`default_nettype wire
